// [hdl/uar_pkg.sv]
// Constants and types of the asynchronous receive recovery block
package uar_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Sampling figures
    localparam logic [4:0] SPB_NORMAL   = 5'h10;
    localparam logic [4:0] SPB_DOUBLE   = 5'h08;
    localparam logic [4:0] VOTE_NORMAL  = 5'h08;
    localparam logic [4:0] VOTE_DOUBLE  = 5'h04;
    localparam logic [4:0] GUARD_DOUBLE = 5'h07;
    localparam logic [3:0] FRAME_MIN    = 4'h5;
    localparam logic [3:0] FRAME_MAX    = 4'ha;
    localparam int         WORD_W       = 10;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [4:0]        SMP_RST   = 5'h00;
    localparam logic [3:0]        BITN_RST  = 4'h0;
    localparam logic [WORD_W-1:0] SHIFT_RST = 10'h000;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_START = 4'h2,
        ST_BITS  = 4'h4,
        ST_GUARD = 4'h8
    } uar_state_e;

    typedef struct packed {
        logic [WORD_W-1:0] data;
        logic              frame_error_flag;
        logic              overrun;
    } uar_entry_s;

    typedef struct packed {
        uar_state_e        st;
        logic [4:0]        smp;
        logic [3:0]        bitn;
        logic [3:0]        nbits;
        logic              ds;
        logic [1:0]        vs;
        logic              prev_rx;
        logic [WORD_W-1:0] shift;
        logic              lost;
        logic              busy;
        uar_entry_s        b0;
        logic              v0;
        uar_entry_s        b1;
        logic              v1;
    } uar_regs_s;

endpackage

// [hdl/uar_rx_recovery.sv]
// Oversampling start detector, bit recovery and two-entry output buffer
`timescale 1ns/100ps
`default_nettype none

module uar_rx_recovery
(
    input  wire logic               i_core_clk,
    input  wire logic               i_rstn,
    input  wire logic               i_rx_enable,
    input  wire logic               i_double_speed_select,
    input  wire logic               i_sample_tick,
    input  wire logic [3:0]         i_frame_bits,
    input  wire logic               i_rxd,
    input  wire logic               i_out_ready,
    output logic                    o_out_valid,
    output uar_pkg::uar_entry_s     o_out_word,
    output logic                    o_busy
);
    import uar_pkg::*;

    uar_regs_s  s_q;
    uar_regs_s  s_d;
    logic [4:0] spb;
    logic [4:0] vf;
    logic [4:0] idx;
    logic       maj;
    logic       vote_end;
    logic       stop_end;
    logic       pop;
    logic [3:0] nbits_in;

    ////////////////////////////////////////////////////////////////////////
    // Sample indexing and voting
    assign spb      = s_q.ds ? SPB_DOUBLE : SPB_NORMAL;
    assign vf       = s_q.ds ? VOTE_DOUBLE : VOTE_NORMAL;
    assign idx      = (s_q.smp == spb) ? 5'h01 : s_q.smp + 5'h01;
    assign maj      = (s_q.vs[0] & s_q.vs[1]) | (s_q.vs[0] & i_rxd)
                    | (s_q.vs[1] & i_rxd);
    assign vote_end = i_sample_tick && (idx == vf + 5'h02);
    assign stop_end = vote_end && (s_q.st == ST_BITS)
                   && (s_q.bitn == s_q.nbits);
    assign pop      = s_q.v0 && i_out_ready;
    assign nbits_in = (i_frame_bits < FRAME_MIN) ? FRAME_MIN :
                      (i_frame_bits > FRAME_MAX) ? FRAME_MAX :
                      i_frame_bits;

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        uar_entry_s ent;
        ent = '{data: SHIFT_RST, frame_error_flag: 1'b0, overrun: 1'b0};
        s_d = s_q;
        if (i_sample_tick)
        begin
            s_d.prev_rx = i_rxd;
        end
        unique case (s_q.st)
            ST_IDLE:
            begin
                if (i_sample_tick && s_q.prev_rx && !i_rxd)
                begin
                    s_d.st    = ST_START;
                    s_d.smp   = 5'h01;
                    s_d.ds    = i_double_speed_select;
                    s_d.nbits = nbits_in;
                end
            end
            ST_START:
            begin
                if (i_sample_tick)
                begin
                    s_d.smp = idx;
                    if (idx == vf)
                    begin
                        s_d.vs[0] = i_rxd;
                    end
                    if (idx == vf + 5'h01)
                    begin
                        s_d.vs[1] = i_rxd;
                    end
                    if (vote_end && maj)
                    begin
                        s_d.st = ST_IDLE;
                    end
                    else if (idx == spb)
                    begin
                        // Index stays at the last sample; next tick is 1
                        s_d.st   = ST_BITS;
                        s_d.bitn = BITN_RST;
                    end
                end
            end
            ST_BITS:
            begin
                if (i_sample_tick)
                begin
                    s_d.smp = idx;
                    if (idx == vf)
                    begin
                        s_d.vs[0] = i_rxd;
                    end
                    if (idx == vf + 5'h01)
                    begin
                        s_d.vs[1] = i_rxd;
                    end
                    if (stop_end)
                    begin
                        s_d.st = s_q.ds ? ST_GUARD : ST_IDLE;
                    end
                    else if (vote_end)
                    begin
                        s_d.shift = {maj, s_q.shift[WORD_W-1:1]};
                    end
                    if (idx == spb)
                    begin
                        s_d.bitn = s_q.bitn + 4'h1;
                    end
                end
            end
            ST_GUARD:
            begin
                if (i_sample_tick)
                begin
                    s_d.smp = idx;
                    if (idx == GUARD_DOUBLE)
                    begin
                        s_d.st = ST_IDLE;
                    end
                end
            end
            default:
            begin
                s_d.st = ST_IDLE;
            end
        endcase

        // Right-justify the character and keep the stop verdict with it
        ent.data = s_q.shift >> (4'(WORD_W) - s_q.nbits);
        ent.frame_error_flag = !maj;
        ent.overrun = s_q.lost;

        if (pop)
        begin
            s_d.b0 = s_q.b1;
            s_d.v0 = s_q.v1;
            s_d.v1 = 1'b0;
        end
        if (stop_end)
        begin
            if (!s_d.v0)
            begin
                s_d.b0   = ent;
                s_d.v0   = 1'b1;
                s_d.lost = 1'b0;
            end
            else if (!s_d.v1)
            begin
                s_d.b1   = ent;
                s_d.v1   = 1'b1;
                s_d.lost = 1'b0;
            end
            else
            begin
                s_d.lost = 1'b1;
            end
        end

        if (!i_rx_enable)
        begin
            s_d.st      = ST_IDLE;
            s_d.smp     = SMP_RST;
            s_d.v0      = 1'b0;
            s_d.v1      = 1'b0;
            s_d.lost    = 1'b0;
            s_d.prev_rx = 1'b0;
        end
        s_d.busy = (s_d.st != ST_IDLE);
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            s_q <= '{st: ST_IDLE, smp: SMP_RST, bitn: BITN_RST,
                     nbits: FRAME_MIN, ds: 1'b0, vs: 2'h0, prev_rx: 1'b0,
                     shift: SHIFT_RST, lost: 1'b0, busy: 1'b0,
                     b0: '0, v0: 1'b0, b1: '0, v1: 1'b0};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign o_out_valid = s_q.v0;
    assign o_out_word  = s_q.b0;
    assign o_busy      = s_q.busy;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_rate_range;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (s_q.st != ST_IDLE) |-> (s_q.smp <= (s_q.ds ? 5'h08 : 5'h10));
    endproperty
    a_rate_range: assert property (p_rate_range)
        else $error("sample index beyond bit length");

    property p_start_seen;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (s_q.st == ST_IDLE && i_rx_enable && i_sample_tick
         && s_q.prev_rx && !i_rxd)
        |=> (s_q.st == ST_START && s_q.smp == 5'h01);
    endproperty
    a_start_seen: assert property (p_start_seen)
        else $error("falling edge did not start qualification");

    property p_noise_reject;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (s_q.st == ST_START && vote_end && maj)
        |=> (s_q.st == ST_IDLE);
    endproperty
    a_noise_reject: assert property (p_noise_reject)
        else $error("noisy start bit not rejected");

    property p_start_vote_point;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (s_q.st == ST_START && i_rx_enable && i_sample_tick && idx == vf)
        |=> (s_q.vs[0] == $past(i_rxd));
    endproperty
    a_start_vote_point: assert property (p_start_vote_point)
        else $error("start vote sample not taken at its point");

    property p_align;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (s_q.st == ST_START && i_rx_enable && i_sample_tick && idx == spb)
        |=> (s_q.st == ST_BITS && s_q.bitn == 4'h0
             && s_q.smp == (s_q.ds ? 5'h08 : 5'h10));
    endproperty
    a_align: assert property (p_align)
        else $error("bit timing not aligned after start");

    property p_bit_step;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (s_q.st == ST_BITS && i_rx_enable && i_sample_tick
         && idx == spb && !stop_end)
        |=> (s_q.smp == (s_q.ds ? 5'h08 : 5'h10)
             && s_q.bitn == $past(s_q.bitn) + 4'h1);
    endproperty
    a_bit_step: assert property (p_bit_step)
        else $error("bit counter did not advance");

    property p_stop_frame_error;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (stop_end && i_rx_enable && !s_q.vs[0] && !s_q.vs[1]
         && !s_q.v0)
        |=> (s_q.v0 && s_q.b0.frame_error_flag);
    endproperty
    a_stop_frame_error: assert property (p_stop_frame_error)
        else $error("low stop bit gave no frame error");

    property p_stop_last;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (stop_end && i_rx_enable) |=> (s_q.st != ST_BITS);
    endproperty
    a_stop_last: assert property (p_stop_last)
        else $error("recovery ran past first stop bit");

    property p_early_start;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (stop_end && i_rx_enable && !s_q.ds) |=> (s_q.st == ST_IDLE);
    endproperty
    a_early_start: assert property (p_early_start)
        else $error("normal mode not idle after stop vote");

    property p_guard_entry;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (stop_end && i_rx_enable && s_q.ds)
        |=> (s_q.st == ST_GUARD && s_q.smp == 5'h06);
    endproperty
    a_guard_entry: assert property (p_guard_entry)
        else $error("double speed stop did not enter guard at sample 6");

    property p_frame_len;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (s_q.st != ST_IDLE) |-> (s_q.nbits >= 4'h5 && s_q.nbits <= 4'ha);
    endproperty
    a_frame_len: assert property (p_frame_len)
        else $error("frame length outside five to ten");

    property p_buffer_order;
        @(posedge i_core_clk) disable iff (!i_rstn)
        s_q.v1 |-> s_q.v0;
    endproperty
    a_buffer_order: assert property (p_buffer_order)
        else $error("second entry held without first");

    property p_disable;
        @(posedge i_core_clk) disable iff (!i_rstn)
        !i_rx_enable |=> (s_q.st == ST_IDLE && !o_out_valid && !o_busy);
    endproperty
    a_disable: assert property (p_disable)
        else $error("disable did not return to idle");

endmodule

`default_nettype wire

// [test/testbench.sv]
// Self-checking bench of the receive recovery block
`timescale 1ns/100ps
`default_nettype none

module testbench;
    import uar_pkg::*;

    logic       clk         = 1'b0;
    logic       rstn        = 1'b0;
    logic       en          = 1'b1;
    logic       ds          = 1'b0;
    logic       tick        = 1'b0;
    logic [3:0] nb          = 4'h8;
    logic       rdy         = 1'b0;
    wire logic  rxd;
    logic       vld;
    logic       busy;
    uar_entry_s word;
    int         fails       = 0;
    int         comparisons = 0;
    int         cyc         = 0;

    initial forever #10 clk = ~clk;

    // Oversample strobe on every second clock
    always @(posedge clk) tick <= rstn & ~tick;

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            fails = fails + 1;
            test_done();
        end
    end

    uar_rx_recovery uar_rx_recovery_inst
    (
        .i_core_clk            (clk),
        .i_rstn                (rstn),
        .i_rx_enable           (en),
        .i_double_speed_select (ds),
        .i_sample_tick         (tick),
        .i_frame_bits          (nb),
        .i_rxd                 (rxd),
        .i_out_ready           (rdy),
        .o_out_valid           (vld),
        .o_out_word            (word),
        .o_busy                (busy)
    );

    uar_tx_model uar_tx_model_inst
    (
        .i_core_clk (clk),
        .o_rxd      (rxd)
    );

    ////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic test_done();
        if (fails == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk_word(input logic [11:0] got, input logic [11:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        chk_word({11'h000, got}, {11'h000, exp});
    endtask

    task automatic w(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic snd(input logic [9:0] d, input logic [3:0] n,
                       input int b, input logic s, input int c);
        nb <= n;
        uar_tx_model_inst.send(d, n, b, s, c);
    endtask

    // Waits for the head word, judges it, then pops it
    task automatic get(input logic [11:0] exp);
        int k;
        k = 0;
        #1;
        while (vld !== 1'b1 && k < 1000)
        begin
            @(posedge clk);
            #1;
            k++;
        end
        chk_flag(vld, 1'b1);
        chk_word(word, exp);
        @(posedge clk);
        rdy <= 1'b1;
        @(posedge clk);
        rdy <= 1'b0;
    endtask

    task automatic none();
        #1;
        chk_flag(vld, 1'b0);
        chk_flag(busy, 1'b0);
        @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_len();
        logic [9:0] d;
        for (int m = 0; m < 2; m++)
            for (int n = 5; n <= 10; n++)
            begin
                d = 10'h2b5 ^ 10'(n);
                ds <= m[0];
                snd(d, 4'(n), m ? 16 : 32, 1'b1, m ? 16 : 32);
                get({d & 10'((1 << n) - 1), 2'b00});
            end
        ds <= 1'b0;
        nb <= 4'hf;
        uar_tx_model_inst.send(10'h2a7, 4'ha, 32, 1'b1, 32);
        get({10'h2a7, 2'b00});
    endtask

    task automatic t_ferr();
        ds <= 1'b0;
        snd(10'h0a5, 4'h8, 32, 1'b0, 32);
        w(4);
        snd(10'h05a, 4'h8, 32, 1'b1, 32);
        get({10'h0a5, 2'b10});
        get({10'h05a, 2'b00});
    endtask

    task automatic t_noise();
        int rj [2] = '{16, 8};
        int ac [2] = '{18, 10};
        nb <= 4'h8;
        for (int m = 0; m < 2; m++)
        begin
            ds <= m[0];
            uar_tx_model_inst.pulse(rj[m]);
            w(40);
            none();
            uar_tx_model_inst.pulse(ac[m]);
            get({10'h0ff, 2'b00});
        end
    endtask

    task automatic t_rate();
        ds <= 1'b0;
        snd(10'h3c6, 4'ha, 31, 1'b1, 31);
        w(40);
        snd(10'h139, 4'ha, 33, 1'b1, 33);
        get({10'h3c6, 2'b00});
        get({10'h139, 2'b00});
    endtask

    task automatic t_b2b();
        for (int m = 0; m < 2; m++)
        begin
            ds <= m[0];
            snd(10'h0d2, 4'h8, m ? 16 : 32, 1'b1, m ? 14 : 20);
            snd(10'h02d, 4'h8, m ? 16 : 32, 1'b1, 32);
            get({10'h0d2, 2'b00});
            get({10'h02d, 2'b00});
        end
    endtask

    task automatic t_over();
        ds <= 1'b0;
        snd(10'h011, 4'h8, 32, 1'b1, 32);
        snd(10'h022, 4'h8, 32, 1'b0, 32);
        w(4);
        snd(10'h033, 4'h8, 32, 1'b1, 32);
        get({10'h011, 2'b00});
        get({10'h022, 2'b10});
        snd(10'h044, 4'h8, 32, 1'b1, 32);
        get({10'h044, 2'b01});
        none();
    endtask

    task automatic t_dis();
        snd(10'h055, 4'h8, 32, 1'b1, 32);
        fork
            snd(10'h066, 4'h8, 32, 1'b1, 32);
            begin
                w(100);
                en <= 1'b0;
                #1;
                chk_flag(busy, 1'b1);
                w(2);
                none();
            end
        join
        en <= 1'b1;
        w(4);
        none();
        snd(10'h077, 4'h8, 32, 1'b1, 32);
        get({10'h077, 2'b00});
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        w(3);
        rstn <= 1'b1;
        w(4);
        t_len();
        t_ferr();
        t_noise();
        t_rate();
        t_b2b();
        t_over();
        t_dis();
        test_done();
    end

endmodule
`default_nettype wire

// [test/uar_tx_model.sv]
// Behavioural far-end serial transmitter driving the receive line
`timescale 1ns/100ps
`default_nettype none

module uar_tx_model
(
    input  wire logic i_core_clk,
    output logic      o_rxd
);

    initial o_rxd = 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // One frame; bit and stop lengths in core clocks, line idles high after
    task automatic send(input logic [9:0] d, input logic [3:0] n,
                        input int b, input logic s, input int c);
        o_rxd <= 1'b0;
        repeat (b) @(posedge i_core_clk);
        for (int i = 0; i < n; i++)
        begin
            o_rxd <= d[i];
            repeat (b) @(posedge i_core_clk);
        end
        o_rxd <= s;
        repeat (c) @(posedge i_core_clk);
        o_rxd <= 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Lone low pulse, as a noise spike or a bare start bit
    task automatic pulse(input int l);
        o_rxd <= 1'b0;
        repeat (l) @(posedge i_core_clk);
        o_rxd <= 1'b1;
    endtask

endmodule
`default_nettype wire
